/* src/lfd_map.svh */
// Purpose: Named offsets, field positions, reset values and timing counts of the LF command decoder
// Assumes: Included by bare name from every file that needs a constant
// Notes: Definitions only
`ifndef LFD_MAP_SVH
`define LFD_MAP_SVH

// Immediate command words
`define LFD_CMD_FAULT_CLEAR 8'h40
`define LFD_CMD_CONFIG 8'h48
`define LFD_CMD_CONFIG_MASK 8'hFC
`define LFD_CMD_HALT 8'h50

// Queued command opcodes (bits 7..5) and the data header pattern (bits 7..4)
`define LFD_OP_SELECT 3'h1
`define LFD_OP_CURRENT 3'h5
`define LFD_OP_CARRIER 3'h4
`define LFD_OP_HEADER 4'h0

// Field positions inside command words
`define LFD_OP_MSB 7
`define LFD_OP_LSB 5
`define LFD_HDR_LSB 4
`define LFD_SEL_SPEED_BIT 4
`define LFD_SEL_DIAG_BIT 3
`define LFD_SEL_GROUP_BIT 2
`define LFD_CFG_IDLE_BIT 1
`define LFD_CFG_EDGE_BIT 0

// Reset values
`define LFD_RST_GROUP 1'h0
`define LFD_RST_INDEX 2'h1
`define LFD_RST_DIAG 1'h0
`define LFD_RST_SPEED 1'h0
`define LFD_RST_STEP 5'h00
`define LFD_RST_SERIAL_IDLE 1'h1
`define LFD_RST_SERIAL_EDGE 1'h1

// Timing: one LF period at 125 kHz, system clock 200 MHz
`define LFD_CLK_PERIOD_NS 5
`define LFD_LF_PERIOD_NS 8000
`define LFD_LF_PERIOD_CYCLES (`LFD_LF_PERIOD_NS / `LFD_CLK_PERIOD_NS)

// LF periods per data bit and per LF (half) bit
`define LFD_BIT_PERIODS_NORMAL 6'h20
`define LFD_BIT_PERIODS_FAST 6'h16
`define LFD_HALF_PERIODS_NORMAL 6'h10
`define LFD_HALF_PERIODS_FAST 6'h0B

// FIFO geometry
`define LFD_FIFO_AW 5
`define LFD_FIFO_DEPTH 32

`endif

/* src/lfd_pkg.sv */
// Purpose: Types shared by the LF command decoder files
// Assumes: Used as lfd_pkg::name, never imported
// Notes: Executor states are one-hot
package lfd_pkg;

  typedef enum logic [5:0] {
    LFD_ST_IDLE    = 6'h01,
    LFD_ST_DECODE  = 6'h02,
    LFD_ST_FETCH   = 6'h04,
    LFD_ST_LOAD    = 6'h08,
    LFD_ST_BIT     = 6'h10,
    LFD_ST_CARRIER = 6'h20
  } lfd_state_t;

endpackage

/* src/lfd_mem_if.sv */
// Purpose: Write and read ports between the decoder and its FIFO memory
// Assumes: Both ends on clk_i
// Notes: Read data arrive one clock after rd_en
`timescale 1ns/1ps
`include "lfd_map.svh"
interface lfd_mem_if;
  logic wr_en;
  logic [`LFD_FIFO_AW-1:0] wr_addr;
  logic [7:0] wr_data;
  logic rd_en;
  logic [`LFD_FIFO_AW-1:0] rd_addr;
  logic [7:0] rd_data;

  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_en, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_en, input rd_addr, output rd_data);
endinterface

/* src/lfd_fifo_mem.sv */
// Purpose: Word storage for the LF data FIFO
// Assumes: Pointers kept by the controller
// Notes: Read data held in a register until the next read
`timescale 1ns/1ps
`include "lfd_map.svh"
module lfd_fifo_mem (
  input wire logic clk_i,
  input wire logic reset_n_i,
  lfd_mem_if.mem port
);

  logic [7:0] words [0:`LFD_FIFO_DEPTH-1];

  // Storage has no reset; only written words are ever read
  always_ff @(posedge clk_i)
  begin
    if (port.wr_en)
    begin
      words[port.wr_addr] <= port.wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      port.rd_data <= 8'h00;
    else if (port.rd_en)
      port.rd_data <= words[port.rd_addr];
  end

endmodule

/* src/lfd_decoder.sv */
// Purpose: Serial command decoder and LF driver sequencer
// Assumes: Serial pins and supply status come from outside the clock domain
// Notes: Field changes happen only at LF period boundaries
`timescale 1ns/1ps
`include "lfd_map.svh"
module lfd_decoder (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic mosi_i,
  input wire logic cs_n_i,
  input wire logic supplies_valid_i,
  input wire logic driver_fault_i,
  output logic serial_idle_level_select_o,
  output logic serial_sample_edge_select_o,
  output logic lf_speed_select_o,
  output logic diagnosis_enable_o,
  output logic driver_group_select_o,
  output logic [1:0] driver_index_o,
  output logic [4:0] coil_current_step_o,
  output logic coil_plus_line_test_o,
  output logic coil_minus_line_test_o,
  output logic ready_to_drive_flag_o,
  output logic fault_stored_o,
  output logic coil_drive_o,
  output logic modulator_active_o,
  output logic bit_toggle_o,
  output logic fifo_empty_o,
  output logic fifo_full_o
);

  localparam logic [10:0] LF_LAST = 11'(`LFD_LF_PERIOD_CYCLES - 1);

  function automatic logic is_header(input logic [7:0] b);
    is_header = (b[`LFD_OP_MSB:`LFD_HDR_LSB] == `LFD_OP_HEADER);
  endfunction

  function automatic logic is_op(input logic [7:0] b, input logic [2:0] op);
    is_op = (b[`LFD_OP_MSB:`LFD_OP_LSB] == op);
  endfunction

  lfd_mem_if mem_bus ();

  lfd_fifo_mem u_mem (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .port(mem_bus.mem)
  );

  // Two-stage synchronisers for all pins from outside the clock domain
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic sclk_d;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      // Serial clock starts at its reset idle level (high) so no false edge follows reset
      pin_s1 <= 4'hA;
      pin_s2 <= 4'hA;
      sclk_d <= 1'b1;
    end
    else
    begin
      pin_s1 <= {sclk_i, mosi_i, cs_n_i, supplies_valid_i};
      pin_s2 <= pin_s1;
      sclk_d <= pin_s2[3];
    end
  end

  wire sclk_s = pin_s2[3];
  wire mosi_s = pin_s2[2];
  wire cs_n_s = pin_s2[1];
  wire sup_ok = pin_s2[0];

  // Serial sampling edge from the two configuration bits
  logic serial_idle;
  logic serial_edge;
  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire sample_on_rise = ~(serial_idle ^ serial_edge);
  wire sample_edge = ~cs_n_s & (sample_on_rise ? sclk_rise : sclk_fall);

  // Shift register; a byte counts only once all eight bits are in
  logic [6:0] rx_shift;
  logic [2:0] rx_bits;
  logic [7:0] rx_byte;
  logic byte_valid;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rx_shift <= 7'h00;
      rx_bits <= 3'h0;
      rx_byte <= 8'h00;
      byte_valid <= 1'b0;
    end
    else
    begin
      byte_valid <= 1'b0;
      if (cs_n_s)
        rx_bits <= 3'h0; // Partial word dropped at deselect
      else if (sample_edge)
      begin
        rx_shift <= {rx_shift[5:0], mosi_s};
        rx_bits <= rx_bits + 3'h1;
        if (rx_bits == 3'h7)
        begin
          rx_byte <= {rx_shift, mosi_s};
          byte_valid <= 1'b1;
        end
      end
    end
  end

  // Command classification
  logic [3:0] payload_left;
  logic payload_keep;
  logic ready;
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  wire in_payload = (payload_left != 4'h0);
  wire cmd_byte = byte_valid & ~in_payload;
  wire rx_queued = is_op(rx_byte, `LFD_OP_SELECT) | is_op(rx_byte, `LFD_OP_CURRENT) |
                   is_op(rx_byte, `LFD_OP_CARRIER) | is_header(rx_byte);
  wire fault_clear_cmd = cmd_byte & (rx_byte == `LFD_CMD_FAULT_CLEAR);
  wire config_cmd = cmd_byte & ((rx_byte & `LFD_CMD_CONFIG_MASK) == `LFD_CMD_CONFIG);
  wire halt_cmd = cmd_byte & (rx_byte == `LFD_CMD_HALT);
  wire fifo_empty = (wr_ptr == rd_ptr);
  wire fifo_full = (wr_ptr[5] != rd_ptr[5]) && (wr_ptr[4:0] == rd_ptr[4:0]);

  // queue driver commands and headers; refused when not ready
  wire fifo_wr = byte_valid & ~fifo_full & ~halt_cmd & (in_payload ? payload_keep : (rx_queued & ready));

  // payload byte counting after a header
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      payload_left <= 4'h0;
      payload_keep <= 1'b0;
    end
    else if (byte_valid && in_payload)
      payload_left <= payload_left - 4'h1;
    else if (cmd_byte && is_header(rx_byte))
    begin
      payload_left <= {1'b0, rx_byte[3:1]} + 4'h1;
      payload_keep <= ready;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      serial_idle <= `LFD_RST_SERIAL_IDLE;
      serial_edge <= `LFD_RST_SERIAL_EDGE;
    end
    else if (config_cmd)
    begin
      serial_idle <= rx_byte[`LFD_CFG_IDLE_BIT];
      serial_edge <= rx_byte[`LFD_CFG_EDGE_BIT];
    end
  end

  // Executor state
  lfd_pkg::lfd_state_t state;
  lfd_pkg::lfd_state_t next_state;
  logic [4:0] nib_left;
  logic exec_rd;
  wire [7:0] word = mem_bus.rd_data;
  assign exec_rd = ((state == lfd_pkg::LFD_ST_IDLE) | ((state == lfd_pkg::LFD_ST_FETCH) & (nib_left != 5'h00)))
                   & ~fifo_empty & ~halt_cmd;

  // halt flushes the FIFO pointers at once
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
    end
    else if (halt_cmd)
    begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
    end
    else
    begin
      wr_ptr <= wr_ptr + {5'h00, fifo_wr};
      rd_ptr <= rd_ptr + {5'h00, exec_rd};
    end
  end

  assign mem_bus.wr_en = fifo_wr;
  assign mem_bus.wr_addr = wr_ptr[4:0];
  assign mem_bus.wr_data = rx_byte;
  assign mem_bus.rd_en = exec_rd;
  assign mem_bus.rd_addr = rd_ptr[4:0];

  // Fault store, diagnosis lock and ready flag; a new event beats the clear
  logic fault_stored;
  logic diag_lock;
  logic diag_exit;
  wire clear_ok = fault_clear_cmd & sup_ok;
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      fault_stored <= 1'b0;
      diag_lock <= 1'b0;
      ready <= 1'b0;
    end
    else
    begin
      fault_stored <= driver_fault_i | (fault_stored & ~clear_ok);
      // stay out of operation until fault clear
      diag_lock <= diag_exit | (diag_lock & ~clear_ok);
      // ready needs no fault and valid supplies
      ready <= ~fault_stored & ~diag_lock & sup_ok & ~driver_fault_i & ~diag_exit;
    end
  end

  // LF period divider; one tick marks each period boundary
  logic [10:0] lf_cnt;
  wire lf_tick = (lf_cnt == LF_LAST);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      lf_cnt <= 11'h000;
    else
      lf_cnt <= lf_tick ? 11'h000 : lf_cnt + 11'h001;
  end

  // Driver setup registers
  logic speed;
  logic diag;
  logic group;
  logic [1:0] index;
  logic [4:0] step;
  logic [7:0] bit_shift;
  logic [3:0] bits_left;
  logic [5:0] tick_cnt;
  logic [4:0] units_left;
  logic endless;
  logic bit_step;
  wire [5:0] half_periods = speed ? `LFD_HALF_PERIODS_FAST : `LFD_HALF_PERIODS_NORMAL;
  // data bit time sets the carrier unit
  wire [5:0] unit_periods = speed ? `LFD_BIT_PERIODS_FAST : `LFD_BIT_PERIODS_NORMAL;
  wire half_done = lf_tick & (tick_cnt == half_periods - 6'h01);
  wire unit_done = lf_tick & (tick_cnt == unit_periods - 6'h01);
  wire last_nibble = (nib_left == 5'h01);
  wire dec_select = is_op(word, `LFD_OP_SELECT);
  assign diag_exit = (state == lfd_pkg::LFD_ST_DECODE) & dec_select & diag & ~word[`LFD_SEL_DIAG_BIT] & ~halt_cmd;
  assign bit_step = (state == lfd_pkg::LFD_ST_BIT) & half_done;

  // Next-state selection; halt returns to idle from anywhere
  always_comb
  begin
    next_state = state;
    case (state)
      lfd_pkg::LFD_ST_IDLE:
        if (exec_rd)
          next_state = lfd_pkg::LFD_ST_DECODE;
      lfd_pkg::LFD_ST_DECODE:
        if (is_header(word))
          next_state = lfd_pkg::LFD_ST_FETCH;
        else if (is_op(word, `LFD_OP_CARRIER))
          next_state = lfd_pkg::LFD_ST_CARRIER;
        else
          next_state = lfd_pkg::LFD_ST_IDLE;
      lfd_pkg::LFD_ST_FETCH:
        if (nib_left == 5'h00)
          next_state = lfd_pkg::LFD_ST_IDLE;
        else if (exec_rd)
          next_state = lfd_pkg::LFD_ST_LOAD;
      lfd_pkg::LFD_ST_LOAD:
        next_state = lfd_pkg::LFD_ST_BIT;
      lfd_pkg::LFD_ST_BIT:
        if (bit_step && bits_left == 4'h1)
          next_state = lfd_pkg::LFD_ST_FETCH;
      lfd_pkg::LFD_ST_CARRIER:
        if (unit_done && !endless && units_left == 5'h01)
          next_state = lfd_pkg::LFD_ST_IDLE;
      default:
        next_state = lfd_pkg::LFD_ST_IDLE;
    endcase
    if (halt_cmd)
      next_state = lfd_pkg::LFD_ST_IDLE;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      state <= lfd_pkg::LFD_ST_IDLE;
    else
      state <= next_state;
  end

  // queued commands take effect when they leave the FIFO, in order
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      // channel 1, diagnosis off, normal speed
      group <= `LFD_RST_GROUP;
      index <= `LFD_RST_INDEX;
      diag <= `LFD_RST_DIAG;
      speed <= `LFD_RST_SPEED;
      step <= `LFD_RST_STEP;
    end
    else if (state == lfd_pkg::LFD_ST_DECODE && !halt_cmd)
    begin
      if (dec_select)
      begin
        speed <= word[`LFD_SEL_SPEED_BIT];
        diag <= word[`LFD_SEL_DIAG_BIT];
        group <= word[`LFD_SEL_GROUP_BIT];
        index <= word[1:0];
      end
      if (is_op(word, `LFD_OP_CURRENT))
        step <= word[4:0];
    end
  end

  // Data and carrier sequencing counters
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      nib_left <= 5'h00;
      bit_shift <= 8'h00;
      bits_left <= 4'h0;
      tick_cnt <= 6'h00;
      units_left <= 5'h00;
      endless <= 1'b0;
    end
    else
    begin
      case (state)
        lfd_pkg::LFD_ST_DECODE:
        begin
          // nibble count is field plus one
          nib_left <= {1'b0, word[3:0]} + 5'h01;
          // carrier length in bit times, zero is endless
          units_left <= word[4:0];
          endless <= (word[4:0] == 5'h00);
          tick_cnt <= 6'h00;
        end
        lfd_pkg::LFD_ST_LOAD:
        begin
          // Odd tail carries its nibble in the low bits
          bit_shift <= last_nibble ? {word[3:0], 4'h0} : word;
          bits_left <= last_nibble ? 4'h4 : 4'h8;
          nib_left <= last_nibble ? 5'h00 : nib_left - 5'h02;
          tick_cnt <= 6'h00;
        end
        lfd_pkg::LFD_ST_BIT:
          if (lf_tick)
          begin
            tick_cnt <= half_done ? 6'h00 : tick_cnt + 6'h01;
            if (half_done)
            begin
              bit_shift <= {bit_shift[6:0], 1'b0};
              bits_left <= bits_left - 4'h1;
            end
          end
        lfd_pkg::LFD_ST_CARRIER:
          if (lf_tick)
          begin
            tick_cnt <= unit_done ? 6'h00 : tick_cnt + 6'h01;
            if (unit_done && !endless)
              units_left <= units_left - 5'h01;
          end
        default:
          tick_cnt <= tick_cnt;
      endcase
    end
  end

  // Field enable, modulator active and bit toggle move only on period ticks.
  // The byte fetch gap between data bytes is hidden this way, at the cost
  // of starting each transfer up to one period late.
  wire drive_allowed = ~diag & ready;
  wire sending = (state == lfd_pkg::LFD_ST_BIT) | (state == lfd_pkg::LFD_ST_CARRIER) |
                 (state == lfd_pkg::LFD_ST_LOAD) | ((state == lfd_pkg::LFD_ST_FETCH) & (nib_left != 5'h00));
  wire field_src = (state == lfd_pkg::LFD_ST_CARRIER) | ((state == lfd_pkg::LFD_ST_BIT) & bit_shift[7]);
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      coil_drive_o <= 1'b0;
      modulator_active_o <= 1'b0;
      bit_toggle_o <= 1'b0;
    end
    else if (lf_tick)
    begin
      // stop only at period boundary; diagnosis blocks LF
      coil_drive_o <= field_src & drive_allowed;
      modulator_active_o <= sending & drive_allowed;
      bit_toggle_o <= bit_toggle_o ^ bit_step;
    end
  end

  // Registered setup and status outputs
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      coil_plus_line_test_o <= 1'b0;
      coil_minus_line_test_o <= 1'b0;
      fifo_empty_o <= 1'b1;
      fifo_full_o <= 1'b0;
    end
    else
    begin
      // diagnosis test switches from step bits
      coil_plus_line_test_o <= diag & step[0];
      coil_minus_line_test_o <= diag & step[1];
      fifo_empty_o <= fifo_empty;
      fifo_full_o <= fifo_full;
    end
  end

  assign serial_idle_level_select_o = serial_idle;
  assign serial_sample_edge_select_o = serial_edge;
  assign lf_speed_select_o = speed;
  assign diagnosis_enable_o = diag;
  assign driver_group_select_o = group;
  assign driver_index_o = index;
  assign coil_current_step_o = step;
  assign ready_to_drive_flag_o = ready;
  assign fault_stored_o = fault_stored;

endmodule

/* tb/lfd_spi_master.sv */
// Purpose: Microcontroller model that sends command bytes over the serial pins
// Assumes: Sampling edge follows fall_mode, which the bench sets after each config word that changes the edge
// Notes: Data line gets the inverse of its last bit once released, as nothing pulls it
`timescale 1ns/1ps
module lfd_spi_master (
  output logic sclk_o,
  output logic mosi_o,
  output logic cs_n_o
);
  // Edge on which the design samples: 0 rising, 1 falling
  logic fall_mode = 1'b0;

  initial
  begin
    sclk_o = 1'b1;
    mosi_o = 1'b0;
    cs_n_o = 1'b1;
  end

  // always whole bytes
  // Eight bits MSB first within one select frame; padding nibbles are supplied by the caller
  task automatic send_byte(input logic [7:0] b);
    cs_n_o <= 1'b0;
    #62.5;
    for (int i = 7; i >= 0; i--)
    begin
      // Data moves on the edge that is not sampled
      sclk_o <= fall_mode;
      mosi_o <= b[i];
      #62.5;
      sclk_o <= ~fall_mode;
      #62.5;
    end
    // Hold select past the last edge so the byte is not cut short
    #62.5;
    mosi_o <= ~b[0];
    cs_n_o <= 1'b1;
    #125;
  endtask
endmodule

/* tb/lfd_decoder_assertions.sv */
// Purpose: Port-level properties of the LF command decoder
// Assumes: One clock domain, asynchronous active-low reset
// Notes: The LF tick phase is learnt from the first field change
`timescale 1ns/1ps
module lfd_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic driver_fault_i,
  input wire logic serial_idle_level_select_o,
  input wire logic serial_sample_edge_select_o,
  input wire logic lf_speed_select_o,
  input wire logic diagnosis_enable_o,
  input wire logic driver_group_select_o,
  input wire logic [1:0] driver_index_o,
  input wire logic [4:0] coil_current_step_o,
  input wire logic coil_plus_line_test_o,
  input wire logic coil_minus_line_test_o,
  input wire logic ready_to_drive_flag_o,
  input wire logic fault_stored_o,
  input wire logic coil_drive_o,
  input wire logic modulator_active_o,
  input wire logic fifo_empty_o,
  input wire logic fifo_full_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  logic [10:0] ph;
  logic synced;

  // Phase within the 1600-clock LF period, restarted at every field change
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ph <= 11'h000;
      synced <= 1'b0;
    end
    else if ($changed(coil_drive_o) || $changed(modulator_active_o))
    begin
      ph <= 11'h001;
      synced <= 1'b1;
    end
    else
      ph <= (ph == 11'h63F) ? 11'h000 : ph + 11'h001;
  end

  a_reset_setup_vals: assert property ($past(reset_n_i) == 1'b0 |-> serial_idle_level_select_o && serial_sample_edge_select_o && !diagnosis_enable_o && !lf_speed_select_o && !driver_group_select_o && driver_index_o == 2'h1 && coil_current_step_o == 5'h00) else $error("setup fields wrong after reset");
  a_plus_line_test: assert property (coil_plus_line_test_o == ($past(diagnosis_enable_o) & $past(coil_current_step_o[0]))) else $error("plus line switch wrong");
  a_minus_line_test: assert property (coil_minus_line_test_o == ($past(diagnosis_enable_o) & $past(coil_current_step_o[1]))) else $error("minus line switch wrong");
  a_drive_needs_ready: assert property ($rose(coil_drive_o) |-> $past(ready_to_drive_flag_o) && !$past(diagnosis_enable_o)) else $error("field on without operability");
  a_mod_blocked_diag: assert property ($rose(modulator_active_o) |-> !$past(diagnosis_enable_o)) else $error("modulator active in diagnosis");
  a_fault_sets_store: assert property (driver_fault_i |=> fault_stored_o) else $error("fault not stored");
  a_fault_drops_ready: assert property (fault_stored_o |=> !ready_to_drive_flag_o) else $error("ready with stored fault");
  a_field_on_tick: assert property (synced && ($changed(coil_drive_o) || $changed(modulator_active_o)) |-> ph == 11'h000) else $error("field change off LF boundary");
  a_fifo_flag_excl: assert property (!(fifo_empty_o && fifo_full_o)) else $error("fifo empty and full");
endmodule

bind lfd_decoder lfd_checker i_lfd_checker (.clk_i(clk_i), .reset_n_i(reset_n_i), .driver_fault_i(driver_fault_i),
  .serial_idle_level_select_o(serial_idle_level_select_o), .serial_sample_edge_select_o(serial_sample_edge_select_o),
  .lf_speed_select_o(lf_speed_select_o), .diagnosis_enable_o(diagnosis_enable_o),
  .driver_group_select_o(driver_group_select_o), .driver_index_o(driver_index_o),
  .coil_current_step_o(coil_current_step_o), .coil_plus_line_test_o(coil_plus_line_test_o),
  .coil_minus_line_test_o(coil_minus_line_test_o), .ready_to_drive_flag_o(ready_to_drive_flag_o),
  .fault_stored_o(fault_stored_o), .coil_drive_o(coil_drive_o), .modulator_active_o(modulator_active_o),
  .fifo_empty_o(fifo_empty_o), .fifo_full_o(fifo_full_o));

/* tb/testbench.sv */
// Purpose: Command sequences through the serial pins with expected outputs
// Assumes: Default serial mode; LF period of 1600 clocks
// Notes: Long LF counts kept short by halting telegrams early
`timescale 1ns/1ps
module testbench;
  logic clk_i, reset_n_i, supplies_valid_i, driver_fault_i;
  logic sclk, mosi, cs_n, idle, edg, spd, diag, grp, plus, minus, rdy, flt, drv, mod, tog, emp, full, t0;
  logic [1:0] idx;
  logic [4:0] step;
  int bad_count, checks;
  wire logic [7:0] setup = {3'h0, spd, diag, grp, idx};
  wire logic [7:0] status = {4'h0, rdy, flt, plus, minus};

  lfd_spi_master spi (.sclk_o(sclk), .mosi_o(mosi), .cs_n_o(cs_n));
  lfd_decoder i_lfd_decoder (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .mosi_i(mosi), .cs_n_i(cs_n),
    .supplies_valid_i(supplies_valid_i), .driver_fault_i(driver_fault_i), .serial_idle_level_select_o(idle),
    .serial_sample_edge_select_o(edg), .lf_speed_select_o(spd), .diagnosis_enable_o(diag),
    .driver_group_select_o(grp), .driver_index_o(idx), .coil_current_step_o(step), .coil_plus_line_test_o(plus),
    .coil_minus_line_test_o(minus), .ready_to_drive_flag_o(rdy), .fault_stored_o(flt), .coil_drive_o(drv),
    .modulator_active_o(mod), .bit_toggle_o(tog), .fifo_empty_o(emp), .fifo_full_o(full));

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One byte, then time for the queue to apply it
  task automatic send(input logic [7:0] b);
    spi.send_byte(b);
    repeat (20) @(posedge clk_i);
  endtask

  // Bounded wait for the modulator indicator to reach a level
  task automatic wait_mod(input logic v, input int lim);
    for (int n = 0; n < lim && mod !== v; n++) @(posedge clk_i);
    @(posedge clk_i);
  endtask

  task automatic final_report();
    if (bad_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial
  begin
    #450_000;
    bad_count++;
    final_report();
  end

  initial
  begin
    reset_n_i = 1'b0;
    supplies_valid_i = 1'b1;
    driver_fault_i = 1'b0;
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    for (int n = 0; n < 50 && rdy !== 1'b1; n++) @(posedge clk_i);
    chk("setup", 8'h01, setup);
    chk("step", 8'h00, {3'h0, step});
    chk("config", 8'h03, {6'h00, idle, edg});
    chk("status", 8'h08, status);
    send(8'h48);
    chk("config", 8'h00, {6'h00, idle, edg});
    send(8'h49);
    chk("config", 8'h01, {6'h00, idle, edg});
    // Falling-edge sampling now; the model follows the new edge
    spi.fall_mode = 1'b1;
    send(8'h4B);
    chk("config", 8'h03, {6'h00, idle, edg});
    spi.fall_mode = 1'b0;
    spi.send_byte(8'h21);
    send(8'h36);
    chk("setup", 8'h16, setup);
    send(8'hB3);
    chk("step", 8'h13, {3'h0, step});
    send(8'h2B);
    send(8'hA3);
    chk("setup", 8'h0B, setup);
    chk("status", 8'h0B, status);
    send(8'h31);
    chk("setup", 8'h11, setup);
    chk("status", 8'h00, status);
    send(8'h22);
    chk("setup", 8'h11, setup);
    send(8'h40);
    chk("status", 8'h08, status);
    driver_fault_i <= 1'b1;
    @(posedge clk_i);
    driver_fault_i <= 1'b0;
    supplies_valid_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    chk("status", 8'h04, status);
    send(8'h40);
    chk("status", 8'h04, status);
    supplies_valid_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    send(8'h40);
    chk("status", 8'h08, status);
    // One nibble whose payload looks like a halt word; its upper nibble is padding
    t0 = tog;
    send(8'h00);
    send(8'h50);
    for (int n = 0; n < 22000 && tog === t0; n++) @(posedge clk_i);
    chk("toggle", {7'h00, ~t0}, {7'h00, tog});
    chk("active", 8'h01, {7'h00, mod});
    send(8'h50);
    chk("empty", 8'h01, {7'h00, emp});
    wait_mod(1'b0, 1700);
    chk("active", 8'h00, {7'h00, mod});
    // Endless carrier outlasts one counted unit
    t0 = tog;
    send(8'h80);
    wait_mod(1'b1, 3300);
    // Queued words wait behind the endless carrier until the FIFO is full
    for (int n = 0; n < 32; n++) send(8'hA5);
    chk("full", 8'h01, {7'h00, full});
    chk("step", 8'h03, {3'h0, step});
    repeat (32000) @(posedge clk_i);
    chk("carrier", 8'h03, {6'h00, mod, drv});
    chk("toggle", {7'h00, t0}, {7'h00, tog});
    send(8'h50);
    wait_mod(1'b0, 1700);
    chk("carrier", 8'h00, {6'h00, mod, drv});
    chk("empty", 8'h01, {7'h00, emp});
    chk("full", 8'h00, {7'h00, full});
    chk("step", 8'h03, {3'h0, step});
    final_report();
  end
endmodule
